//--- common/mgmt_gpio_defines.vh
// Register indices, field positions and reset values for the management and media block.
`ifndef MGMT_GPIO_DEFINES_VH
`define MGMT_GPIO_DEFINES_VH

// Register indices; the byte address on the bus is four times the index.
`define IDX_MGMT_EEPROM_PIN_CONTROL 6'h14
`define IDX_TEST_CONTROL            6'h15
`define IDX_GENERAL_INPUT_STATUS    6'h17
`define IDX_EVENT_STATUS            6'h1c
`define IDX_EVENT_MASK              6'h1d

// Management register fields.
`define MGMT_ROM_CLOCK_BIT       7
`define MGMT_ROM_SERIAL_OUT_READ 6
`define MGMT_ROM_SERIAL_IN_DRIVE 5
`define MGMT_ROM_CHIP_SELECT_BIT 4
`define MGMT_DATA_DRIVE          3
`define MGMT_DATA_SAMPLE         2
`define MGMT_DATA_DIRECTION      1
`define MGMT_CLOCK               0

// Write-side test register fields.
`define TEST_COLLISION_BIT  4
`define TEST_PIN_ENABLE_BIT 3
`define TEST_SELECT_HI      2
`define TEST_SELECT_LO      0

// Read-side test register fields.
`define STAT_FAST_IN_RESET  3
`define STAT_SLOW_IN_RESET  2
`define STAT_PHY_RESET_BUSY 1
`define STAT_NEG_DONE       0

// General input register fields.
`define GPI_TWO_BIT       6
`define GPI_ONE_BIT       5
`define GPI_ZERO_BIT      4
`define GPI_INT_SPEED_BIT 2
`define GPI_INT_DUPLEX_BIT 1
`define GPI_INT_LINK_BIT  0

// Output and media control fields.
`define CTRL_PHY_POWER_DOWN   6
`define CTRL_PROGRAM_MEDIA    5
`define CTRL_MEDIA_PRIORITY   4
`define CTRL_GEN_OUTPUT_ZERO  0

// Event status and mask fields.
`define EVT_NEG_DONE     0
`define EVT_INT_LINK     1
`define EVT_EXT_LINK     2
`define EVT_MEDIA_CHANGE 3
`define EVT_WIDTH        4

// Reset values.
`define RST_MGMT_EEPROM_PIN_CONTROL 8'h00
`define RST_TEST_CONTROL            8'h00
`define RST_OUTPUT_MEDIA_CONTROL    8'h00
`define RST_EVENT_MASK              4'h0

`endif

//--- core/sync_bank.v
// Two-stage synchroniser for a bank of asynchronous input levels.
`timescale 1ns/1ps
module sync_bank #(
	parameter WIDTH = 1
) (
	input  wire             sys_clk,
	input  wire             rst_b,
	input  wire [WIDTH-1:0] asyncIn,
	output reg  [WIDTH-1:0] syncOut
);

	reg [WIDTH-1:0] firstStage;

	always @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			firstStage <= {WIDTH{1'b0}};
			syncOut    <= {WIDTH{1'b0}};
		end else begin
			firstStage <= asyncIn;
			syncOut    <= firstStage;
		end
	end

endmodule

//--- core/mgmt_gpio_media_select.v
// Management pin, general-purpose I/O and media selection registers on Wishbone.
//
// Functional notes
// - Serial ROM clock, chip select and data in follow management bits 7, 4, 5.
// - Management bit 6 is read-only and shows the serial ROM data output pin.
// - With direction bit 0, the management data pin is driven from bit 3.
// - Management bit 2 is read-only and shows the level on the management data pin.
// - Bit 1 set releases the management data pin; cleared drives it.
// - Management clock pin follows management bit 0, so software makes each edge.
// - Read test bit 3 is high while the fast PHY logic is in reset.
// - Read test bit 2 is high while the slow PHY logic is in reset.
// - Read test bit 1 is high while the whole internal PHY is in reset.
// - Read test bit 0 rises on negotiation completion, falls on restart.
// - Input bits 6, 5, 4 show live general inputs 2, 1, 0.
// - Input bit 2 shows internal speed, bit 1 internal duplex.
// - Input bit 0 shows internal link status, high when link is up.
// - Control bit 6 set powers down internal PHY and MAC; zero is normal.
// - With priority select 1, program media bit 5 alone chooses; 1 means external.
// - With priority select 1 and program media 0, the internal PHY is chosen.
// - Control bit 0, reset zero, drives general output zero inverted.
//
// The Wishbone register port was left to the implementer.
`timescale 1ns/1ps
`include "mgmt_gpio_defines.vh"

module mgmt_gpio_media_select (
	input  wire        sys_clk,
	input  wire        rst_b,
	input  wire        wb_cyc_i,
	input  wire        wb_stb_i,
	input  wire        wb_we_i,
	input  wire [7:0]  wb_adr_i,
	input  wire [3:0]  wb_sel_i,
	input  wire [31:0] wb_dat_i,
	output reg  [31:0] wb_dat_o,
	output reg         wb_ack_o,
	output reg         romClock,
	output reg         romChipSelect,
	output reg         romDataIn,
	input  wire        romDataOut,
	output reg         mdc,
	input  wire        mdioIn,
	output reg         mdioOut,
	output reg         mdioOe,
	input  wire        fastInReset,
	input  wire        slowInReset,
	input  wire        phyResetBusy,
	input  wire        negotiationDone,
	input  wire [2:0]  genInput,
	input  wire        internalSpeed,
	input  wire        internalDuplex,
	input  wire        internalLink,
	output reg         collisionTest,
	output reg         testPinEnable,
	output reg  [2:0]  testSelect,
	output reg         phyPowerDown,
	output reg         macPowerDown,
	output reg         genOutputZeroInverted,
	output reg         mediaExternal,
	output reg         irq
);

	localparam SYNC_WIDTH = 12;

	// Pin and PHY status levels after two-stage synchronisation.
	wire [SYNC_WIDTH-1:0] syncLevels;
	wire                  romOutSync;
	wire                  mdioSync;
	wire                  fastResetSync;
	wire                  slowResetSync;
	wire                  busyResetSync;
	wire                  negDoneSync;
	wire [2:0]            genInputSync;
	wire                  speedSync;
	wire                  duplexSync;
	wire                  linkSync;

	sync_bank #(
		.WIDTH (SYNC_WIDTH)
	) u_sync (
		.sys_clk (sys_clk),
		.rst_b   (rst_b),
		.asyncIn ({romDataOut, mdioIn, fastInReset, slowInReset, phyResetBusy,
			negotiationDone, genInput, internalSpeed, internalDuplex, internalLink}),
		.syncOut (syncLevels)
	);

	assign romOutSync    = syncLevels[11];
	assign mdioSync      = syncLevels[10];
	assign fastResetSync = syncLevels[9];
	assign slowResetSync = syncLevels[8];
	assign busyResetSync = syncLevels[7];
	assign negDoneSync   = syncLevels[6];
	assign genInputSync  = syncLevels[5:3];
	assign speedSync     = syncLevels[2];
	assign duplexSync    = syncLevels[1];
	assign linkSync      = syncLevels[0];

	// Software-visible register state.
	reg [7:0]            mgmtControl;
	reg [7:0]            testControl;
	reg [7:0]            mediaControl;
	reg [`EVT_WIDTH-1:0] eventStatus;
	reg [`EVT_WIDTH-1:0] eventMask;

	// Previous samples used to detect events.
	reg negDonePrev;
	reg linkPrev;
	reg extLinkPrev;

	wire       request;
	wire       writeTaken;
	wire [5:0] regIndex;
	wire       writeLow;

	assign request    = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	assign writeTaken = request & wb_we_i;
	assign regIndex   = wb_adr_i[7:2];
	assign writeLow   = wb_sel_i[0];

	// True when a write with the low byte lane enabled targets the given index.
	function writeHit;
		input       taken;
		input       lane;
		input [5:0] index;
		input [5:0] target;
		begin
			writeHit = taken & lane & (index == target);
		end
	endfunction

	wire hitMgmt;
	wire hitTest;
	wire hitMedia;
	wire hitStatus;
	wire hitMask;

	assign hitMgmt   = writeHit(writeTaken, writeLow, regIndex, `IDX_MGMT_EEPROM_PIN_CONTROL);
	assign hitTest   = writeHit(writeTaken, writeLow, regIndex, `IDX_TEST_CONTROL);
	assign hitMedia  = writeHit(writeTaken, writeLow, regIndex, `IDX_GENERAL_INPUT_STATUS);
	assign hitStatus = writeHit(writeTaken, writeLow, regIndex, `IDX_EVENT_STATUS);
	assign hitMask   = writeHit(writeTaken, writeLow, regIndex, `IDX_EVENT_MASK);

	// Bus slave: every request, mapped or not, is acknowledged one cycle after it is seen.
	always @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			wb_ack_o <= 1'b0;
		end else begin
			wb_ack_o <= request;
		end
	end

	// Management register; all eight bits are stored, and reads show pin levels in bits 6 and 2.
	always @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			mgmtControl <= `RST_MGMT_EEPROM_PIN_CONTROL;
		end else if (hitMgmt) begin
			mgmtControl <= wb_dat_i[7:0];
		end
	end

	// Write-side test register.
	always @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			testControl <= `RST_TEST_CONTROL;
		end else if (hitTest) begin
			testControl <= wb_dat_i[7:0];
		end
	end

	// Output and media control register.
	always @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			mediaControl <= `RST_OUTPUT_MEDIA_CONTROL;
		end else if (hitMedia) begin
			mediaControl <= wb_dat_i[7:0];
		end
	end

	// Event mask register.
	always @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			eventMask <= `RST_EVENT_MASK;
		end else if (hitMask) begin
			eventMask <= wb_dat_i[`EVT_WIDTH-1:0];
		end
	end

	// Media choice from the priority select, program bit and link levels.
	reg next_mediaExternal;

	always @* begin
		if (mediaControl[`CTRL_MEDIA_PRIORITY]) begin
			next_mediaExternal = mediaControl[`CTRL_PROGRAM_MEDIA];
		end else begin
			next_mediaExternal = ~linkSync & ~genInputSync[0];
		end
	end

	// Event detection.
	wire [`EVT_WIDTH-1:0] eventPulse;

	assign eventPulse[`EVT_NEG_DONE]     = negDoneSync & ~negDonePrev;
	assign eventPulse[`EVT_INT_LINK]     = linkSync ^ linkPrev;
	assign eventPulse[`EVT_EXT_LINK]     = genInputSync[0] ^ extLinkPrev;
	assign eventPulse[`EVT_MEDIA_CHANGE] = next_mediaExternal ^ mediaExternal;

	always @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			negDonePrev <= 1'b0;
			linkPrev    <= 1'b0;
			extLinkPrev <= 1'b0;
		end else begin
			negDonePrev <= negDoneSync;
			linkPrev    <= linkSync;
			extLinkPrev <= genInputSync[0];
		end
	end

	// Sticky event bits, cleared by writing one; a new event in the same cycle wins.
	wire [`EVT_WIDTH-1:0] clearMask;

	assign clearMask = hitStatus ? wb_dat_i[`EVT_WIDTH-1:0] : {`EVT_WIDTH{1'b0}};

	always @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			eventStatus <= {`EVT_WIDTH{1'b0}};
		end else begin
			eventStatus <= (eventStatus & ~clearMask) | eventPulse;
		end
	end

	// Interrupt level follows the masked status one cycle later.
	always @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			irq <= 1'b0;
		end else begin
			irq <= |(eventStatus & eventMask);
		end
	end

	// Serial ROM and management pins.
	always @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			romClock      <= 1'b0;
			romChipSelect <= 1'b0;
			romDataIn     <= 1'b0;
			mdc           <= 1'b0;
			mdioOut       <= 1'b0;
			mdioOe        <= 1'b1;
		end else begin
			romClock      <= mgmtControl[`MGMT_ROM_CLOCK_BIT];
			romChipSelect <= mgmtControl[`MGMT_ROM_CHIP_SELECT_BIT];
			romDataIn     <= mgmtControl[`MGMT_ROM_SERIAL_IN_DRIVE];
			mdc           <= mgmtControl[`MGMT_CLOCK];
			mdioOut       <= mgmtControl[`MGMT_DATA_DRIVE];
			mdioOe        <= ~mgmtControl[`MGMT_DATA_DIRECTION];
		end
	end

	// Test, power, general output and media pins.
	always @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			collisionTest         <= 1'b0;
			testPinEnable         <= 1'b0;
			testSelect            <= 3'h0;
			phyPowerDown          <= 1'b0;
			macPowerDown          <= 1'b0;
			genOutputZeroInverted <= 1'b1;
			mediaExternal         <= 1'b0;
		end else begin
			collisionTest         <= testControl[`TEST_COLLISION_BIT];
			testPinEnable         <= testControl[`TEST_PIN_ENABLE_BIT];
			testSelect            <= testControl[`TEST_SELECT_HI:`TEST_SELECT_LO];
			phyPowerDown          <= mediaControl[`CTRL_PHY_POWER_DOWN];
			macPowerDown          <= mediaControl[`CTRL_PHY_POWER_DOWN];
			genOutputZeroInverted <= ~mediaControl[`CTRL_GEN_OUTPUT_ZERO];
			mediaExternal         <= next_mediaExternal;
		end
	end

	// Read data multiplexer.
	reg [7:0] next_readByte;

	always @* begin
		next_readByte = 8'h00;
		case (regIndex)
			`IDX_MGMT_EEPROM_PIN_CONTROL: begin
				next_readByte = mgmtControl;
				next_readByte[`MGMT_ROM_SERIAL_OUT_READ] = romOutSync;
				next_readByte[`MGMT_DATA_SAMPLE] = mdioSync;
			end
			`IDX_TEST_CONTROL: begin
				next_readByte[`STAT_FAST_IN_RESET] = fastResetSync;
				next_readByte[`STAT_SLOW_IN_RESET] = slowResetSync;
				next_readByte[`STAT_PHY_RESET_BUSY] = busyResetSync;
				next_readByte[`STAT_NEG_DONE] = negDoneSync;
			end
			`IDX_GENERAL_INPUT_STATUS: begin
				next_readByte[`GPI_TWO_BIT] = genInputSync[2];
				next_readByte[`GPI_ONE_BIT] = genInputSync[1];
				next_readByte[`GPI_ZERO_BIT] = genInputSync[0];
				next_readByte[`GPI_INT_SPEED_BIT] = speedSync;
				next_readByte[`GPI_INT_DUPLEX_BIT] = duplexSync;
				next_readByte[`GPI_INT_LINK_BIT] = linkSync;
			end
			`IDX_EVENT_STATUS: begin
				next_readByte[`EVT_WIDTH-1:0] = eventStatus;
			end
			`IDX_EVENT_MASK: begin
				next_readByte[`EVT_WIDTH-1:0] = eventMask;
			end
			default: begin
				next_readByte = 8'h00;
			end
		endcase
	end

	// Read data is captured with the acknowledge and is zero otherwise.
	always @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			wb_dat_o <= 32'h00000000;
		end else if (request & ~wb_we_i) begin
			wb_dat_o <= {24'h000000, next_readByte};
		end else begin
			wb_dat_o <= 32'h00000000;
		end
	end

endmodule

//--- verif/mgmt_gpio_chk.sv
// Port-level assertions for the management and media register block.
`timescale 1ns/1ps
module mgmt_gpio_chk (
	input wire        sys_clk,
	input wire        rst_b,
	input wire        wb_cyc_i,
	input wire        wb_stb_i,
	input wire        wb_we_i,
	input wire [7:0]  wb_adr_i,
	input wire [3:0]  wb_sel_i,
	input wire [31:0] wb_dat_i,
	input wire [31:0] wb_dat_o,
	input wire        wb_ack_o,
	input wire        romClock,
	input wire        romChipSelect,
	input wire        romDataIn,
	input wire        mdc,
	input wire        mdioOut,
	input wire        mdioOe,
	input wire        phyPowerDown,
	input wire        macPowerDown,
	input wire        genOutputZeroInverted,
	input wire        mediaExternal
);
	wire       wr  = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o & wb_sel_i[0];
	wire [5:0] idx = wb_adr_i[7:2];
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!rst_b);
	property p_ack;
		wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o;
	endproperty
	a_ack: assert property (p_ack)
		else $error("ack is not one pulse after a request");
	property p_idle;
		!wb_ack_o |-> wb_dat_o == 32'h0;
	endproperty
	a_idle: assert property (p_idle)
		else $error("read data not zero outside ack");
	property p_unmapped;
		wb_ack_o && !wb_we_i && !(idx inside {6'h14, 6'h15, 6'h17, 6'h1c, 6'h1d})
			|-> wb_dat_o == 32'h0;
	endproperty
	a_unmapped: assert property (p_unmapped)
		else $error("unmapped read not zero");
	property p_rom;
		wr && idx == 6'h14 |-> ##2
			{romClock, romDataIn, romChipSelect} == $past({wb_dat_i[7], wb_dat_i[5:4]}, 2);
	endproperty
	a_rom: assert property (p_rom)
		else $error("rom pins differ from written bits");
	property p_mdc;
		wr && idx == 6'h14 |-> ##2 mdc == $past(wb_dat_i[0], 2);
	endproperty
	a_mdc: assert property (p_mdc)
		else $error("mdc differs from written bit");
	property p_mdio;
		wr && idx == 6'h14 |-> ##2 {mdioOe, mdioOut} == $past({~wb_dat_i[1], wb_dat_i[3]}, 2);
	endproperty
	a_mdio: assert property (p_mdio)
		else $error("mdio drive differs from written bits");
	property p_pwr;
		wr && idx == 6'h17 |-> ##2 phyPowerDown == $past(wb_dat_i[6], 2) && macPowerDown == phyPowerDown;
	endproperty
	a_pwr: assert property (p_pwr)
		else $error("power down differs from written bit");
	property p_gpo;
		wr && idx == 6'h17 |-> ##2 genOutputZeroInverted == !$past(wb_dat_i[0], 2);
	endproperty
	a_gpo: assert property (p_gpo)
		else $error("general output not inverted bit");
	property p_media;
		wr && idx == 6'h17 && wb_dat_i[4] |-> ##2 mediaExternal == $past(wb_dat_i[5], 2);
	endproperty
	a_media: assert property (p_media)
		else $error("programmed media choice not followed");
endmodule
bind mgmt_gpio_media_select mgmt_gpio_chk i_chk (.sys_clk(sys_clk), .rst_b(rst_b),
	.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
	.wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
	.romClock(romClock), .romChipSelect(romChipSelect), .romDataIn(romDataIn), .mdc(mdc),
	.mdioOut(mdioOut), .mdioOe(mdioOe), .phyPowerDown(phyPowerDown),
	.macPowerDown(macPowerDown), .genOutputZeroInverted(genOutputZeroInverted),
	.mediaExternal(mediaExternal));

//--- verif/rom_phy_partner.sv
// Behavioural serial ROM and management PHY on the far side of the pins.
`timescale 1ns/1ps
module rom_phy_partner (
	input  wire romClock,
	input  wire romChipSelect,
	input  wire romDataIn,
	input  wire mdc,
	input  wire mdioOut,
	input  wire mdioOe,
	output reg  romDataOut,
	output wire mdioIn
);
	reg phyBit;
	reg csHigh;
	initial begin
		romDataOut = 1'b0;
		phyBit     = 1'b0;
		csHigh     = 1'b0;
	end
	always @(posedge romChipSelect) begin
		csHigh <= 1'b1;
	end
	always @(posedge romClock) begin
		if (romChipSelect)
			romDataOut <= romDataIn;
	end
	// A deselected ROM stops holding its output, so show the opposite level.
	// Only a real high-to-low select counts, not the unknown-to-low step at reset.
	always @(negedge romChipSelect) begin
		if (csHigh)
			romDataOut <= ~romDataOut;
		csHigh <= 1'b0;
	end
	always @(posedge mdc) begin
		phyBit <= ~phyBit;
	end
	assign mdioIn = mdioOe ? mdioOut : phyBit;
endmodule

//--- verif/mgmt_gpio_media_select_tb.sv
// Self-checking bench for the management and media register block.
`timescale 1ns/1ps
module mgmt_gpio_media_select_tb;
	reg         clk = 1'b0;
	reg         rstB = 1'b0;
	reg         cyc = 1'b0;
	reg         stb = 1'b0;
	reg         we = 1'b0;
	reg  [7:0]  adr = 8'h00;
	reg  [31:0] datI = 32'h0;
	reg  [3:0]  sel = 4'h0;
	reg  [3:0]  lane = 4'hf;
	reg  [9:0]  s = 10'h000;
	reg  [7:0]  mg = 8'h00;
	reg  [7:0]  v;
	reg  [31:0] q;
	reg         rom = 1'b0;
	reg         ph = 1'b0;
	integer     i;
	integer     cycles = 0;
	integer     checks = 0;
	integer     n_mismatch = 0;
	wire [31:0] datO;
	wire [2:0]  tsel;
	wire        ack, rClk, rCs, rDin, rDout, mdc, mdioIn, mdioOut, mdioOe;
	wire        colT, test_pin_enable, ppd, mpd, gpoN, mExt, irq;
	rom_phy_partner i_rom_phy_partner (.romClock(rClk), .romChipSelect(rCs),
		.romDataIn(rDin), .mdc(mdc), .mdioOut(mdioOut), .mdioOe(mdioOe),
		.romDataOut(rDout), .mdioIn(mdioIn));
	mgmt_gpio_media_select i_mgmt_gpio_media_select (.sys_clk(clk), .rst_b(rstB),
		.wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
		.wb_dat_i(datI), .wb_dat_o(datO), .wb_ack_o(ack), .romClock(rClk),
		.romChipSelect(rCs), .romDataIn(rDin), .romDataOut(rDout), .mdc(mdc),
		.mdioIn(mdioIn), .mdioOut(mdioOut), .mdioOe(mdioOe), .fastInReset(s[3]),
		.slowInReset(s[2]), .phyResetBusy(s[1]), .negotiationDone(s[0]),
		.genInput(s[6:4]), .internalSpeed(s[9]), .internalDuplex(s[8]),
		.internalLink(s[7]), .collisionTest(colT), .testPinEnable(test_pin_enable),
		.testSelect(tsel), .phyPowerDown(ppd), .macPowerDown(mpd),
		.genOutputZeroInverted(gpoN), .mediaExternal(mExt), .irq(irq));
	always #10 clk = ~clk;
	task close_out;
		begin
			$display("checks %0d mismatches %0d", checks, n_mismatch);
			if (n_mismatch == 0 && checks > 0)
				$display("Finished cleanly");
			else
				$display("Finished with errors");
			$finish;
		end
	endtask
	always @(posedge clk) begin
		cycles = cycles + 1;
		if (cycles == 5000) begin
			n_mismatch = n_mismatch + 1;
			close_out;
		end
	end
	task chkPin(input string nm, input logic e, input logic g);
		checks = checks + 1;
		if (g !== e) begin
			n_mismatch = n_mismatch + 1;
			$display("[FAIL] %s exp %b got %b", nm, e, g);
		end
	endtask
	task bus(input logic w, input logic [7:0] a, input logic [7:0] d);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		sel <= lane;
		datI <= {24'h0, d};
		do @(posedge clk); while (ack !== 1'b1);
		q = datO;
		cyc <= 1'b0;
		stb <= 1'b0;
		sel <= 4'h0;
		@(posedge clk);
	endtask
	task rdChk(input logic [7:0] a, input logic [31:0] e);
		bus(1'b0, a, 8'h00);
		checks = checks + 1;
		if (q !== e) begin
			n_mismatch = n_mismatch + 1;
			$display("[FAIL] reg %h exp %h got %h", a, e, q);
		end
	endtask
	// Clock held still while select and data move, so the ROM never sees a race.
	task mgWrite(input logic [7:0] n);
		bus(1'b1, 8'h50, {mg[7], n[6:0]});
		if (mg[4] && !n[4])
			rom = ~rom;
		if (n[0] && !mg[0])
			ph = ~ph;
		bus(1'b1, 8'h50, n);
		if (n[7] && !mg[7] && n[4])
			rom = n[5];
		mg = n;
	endtask
	initial begin
		v = $urandom(32'hd8bcb2fb);
		repeat (6) @(posedge clk);
		rstB <= 1'b1;
		repeat (4) @(posedge clk);
		chkPin("mdioOe", 1'b1, mdioOe);
		chkPin("genOutputZeroInverted", 1'b1, gpoN);
		rdChk(8'h50, 32'h0);
		rdChk(8'h74, 32'h0);
		rdChk(8'h40, 32'h0);
		bus(1'b1, 8'h54, 8'h00);
		chkPin("testBits", 1'b0, colT | test_pin_enable | (|tsel));
		repeat (14) begin
			v = $urandom;
			mgWrite(v);
			repeat (3) @(posedge clk);
			chkPin("romClock", v[7], rClk);
			chkPin("romChipSelect", v[4], rCs);
			chkPin("romDataIn", v[5], rDin);
			chkPin("mdioOut", v[3], mdioOut);
			chkPin("mdioOe", !v[1], mdioOe);
			chkPin("mdc", v[0], mdc);
			rdChk(8'h50, {24'h0, mg[7], rom, mg[5:3], mg[1] ? ph : mg[3], mg[1:0]});
		end
		repeat (10) begin
			s <= $urandom;
			repeat (4) @(posedge clk);
			rdChk(8'h54, {28'h0, s[3:0]});
			rdChk(8'h5c, {25'h0, s[6:4], 1'b0, s[9:7]});
		end
		for (i = 0; i < 16; i = i + 1) begin
			v = $urandom;
			s <= {s[9:8], i[1], s[6:5], i[0], s[3:0]};
			bus(1'b1, 8'h5c, {1'b0, v[6], i[2], i[3], 3'b0, v[0]});
			repeat (4) @(posedge clk);
			chkPin("mediaExternal", i[3] ? i[2] : !(i[1] | i[0]), mExt);
			chkPin("phyPowerDown", v[6], ppd);
			chkPin("macPowerDown", v[6], mpd);
			chkPin("genOutputZeroInverted", !v[0], gpoN);
		end
		s <= {s[9:1], 1'b0};
		repeat (4) @(posedge clk);
		bus(1'b1, 8'h70, 8'h0f);
		rdChk(8'h70, 32'h0);
		bus(1'b1, 8'h74, 8'h01);
		chkPin("irq", 1'b0, irq);
		s <= {s[9:1], 1'b1};
		repeat (4) @(posedge clk);
		rdChk(8'h70, 32'h1);
		chkPin("irq", 1'b1, irq);
		bus(1'b1, 8'h74, 8'h00);
		chkPin("irq", 1'b0, irq);
		bus(1'b1, 8'h74, 8'h01);
		bus(1'b1, 8'h70, 8'h01);
		chkPin("irq", 1'b0, irq);
		rdChk(8'h70, 32'h0);
		// A write without the low byte lane is acknowledged but stores nothing.
		lane = 4'he;
		bus(1'b1, 8'h74, 8'h00);
		lane = 4'hf;
		rdChk(8'h74, 32'h1);
		close_out;
	end
endmodule
